// >>> rtl/rsdo_pkg.sv
/*
  Constants, field layout and types shared by the reset and shared
  digital output block.
  Assumes the serial interface logic presents mode register writes as a
  one-cycle strobe with data, on the same clock as this block.
*/
// Functional notes
// RULE1 - While the hardware reset pin is low, the control, interface, filter and modulator logic and all registers return to their power-on state.
// RULE2 - The hardware reset leaves the clock oscillator running while everything else is reset.
// RULE3 - Shared pin a is an analog input or digital output one, chosen by the digital output enable bit.
// RULE4 - Shared pin b is an analog input or digital output zero, chosen by the same enable bit.
// RULE5 - With outputs enabled, shared pin a is driven to output bit one of the mode register, set by host writes.
// RULE6 - With outputs enabled, shared pin b is driven to output bit zero of the mode register, set by host writes.
// RULE7 - After reset the enable bit is clear, so both shared pins are analog inputs and undriven.

`default_nettype none

package rsdo_pkg;

  // ----------------------------------------------------------------
  // Mode register field layout
  // ----------------------------------------------------------------
  localparam int unsigned MODE_W           = 3;
  localparam int unsigned MODE_BIT_ZERO    = 0;  // Output bit zero
  localparam int unsigned MODE_BIT_ONE     = 1;  // Output bit one
  localparam int unsigned MODE_BIT_DEN     = 2;  // Digital output enable

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [MODE_W-1:0] MODE_RESET = 3'h0;
  localparam logic              PIN_RESET  = 1'h0;
  localparam logic              OE_N_OFF   = 1'h1;
  localparam logic              OSC_ON     = 1'h1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [MODE_W-1:0] rsdo_mode_t;

  typedef enum logic [1:0] {
    RSDO_ST_POWERUP,
    RSDO_ST_HELD,
    RSDO_ST_RUN
  } rsdo_state_t;

endpackage : rsdo_pkg

`default_nettype wire

// >>> rtl/rsdo_sync.sv
/*
  Two-stage synchroniser for a level arriving from a pin.
  Assumes one clock; the asynchronous reset sets both stages to the
  given constant level.
*/
`timescale 1ns/1ps
`default_nettype none

module rsdo_sync #(
  parameter logic RESET_LEVEL = 1'h0
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic async_in,
  output logic      sync_out
);
  import rsdo_pkg::*;

  logic stage1_q;
  logic stage2_q;

  // ----------------------------------------------------------------
  // Synchroniser stages
  // ----------------------------------------------------------------
  // First stage feeds only the second stage
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_q <= RESET_LEVEL;
      stage2_q <= RESET_LEVEL;
    end else begin
      stage1_q <= async_in;
      stage2_q <= stage1_q;
    end
  end

  assign sync_out = stage2_q;

endmodule : rsdo_sync

`default_nettype wire

// >>> rtl/rsdo_top.sv
/*
  Hardware reset handling and the two shared analog/digital output pins.
  Assumes the hardware reset pin is asynchronous to sys_clk, the master
  clock is not gated by this block, and mode writes come from serial
  interface logic on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module rsdo_top (
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire logic               hw_reset_pin_n,
  input  wire logic               mode_wr_en,
  input  wire rsdo_pkg::rsdo_mode_t mode_wr_data,
  output logic                    core_reset_n,
  output logic                    osc_run,
  output rsdo_pkg::rsdo_mode_t    mode_rd_data,
  output logic                    shared_pin_a_o,
  output logic                    shared_pin_a_oe_n,
  output logic                    shared_pin_a_analog,
  output logic                    shared_pin_b_o,
  output logic                    shared_pin_b_oe_n,
  output logic                    shared_pin_b_analog
);
  import rsdo_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic        hw_rst_run;     // Synchronised pin, high when not in reset
  rsdo_state_t state_q;
  rsdo_state_t state_d;
  logic        core_reset_n_q;
  logic        core_reset_n_d;
  logic        osc_run_q;
  logic        osc_run_d;
  rsdo_mode_t  mode_q;
  rsdo_mode_t  mode_d;
  logic        pin_a_o_q;
  logic        pin_a_o_d;
  logic        pin_a_oe_n_q;
  logic        pin_a_oe_n_d;
  logic        pin_b_o_q;
  logic        pin_b_o_d;
  logic        pin_b_oe_n_q;
  logic        pin_b_oe_n_d;

  // ----------------------------------------------------------------
  // Reset pin synchroniser
  // ----------------------------------------------------------------
  // Pin starts out as asserted until two clean samples say otherwise
  rsdo_sync #(
    .RESET_LEVEL (1'h0)
  ) u_reset_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in (hw_reset_pin_n),
    .sync_out (hw_rst_run)
  );

  // ----------------------------------------------------------------
  // Reset sequencing
  // ----------------------------------------------------------------
  // Tracks power-up, held-in-reset and running phases
  always_comb begin
    state_d        = state_q;
    core_reset_n_d = 1'h0;
    case (state_q)
      RSDO_ST_POWERUP: begin
        state_d = hw_rst_run ? RSDO_ST_RUN : RSDO_ST_HELD;
      end
      RSDO_ST_HELD: begin
        if (hw_rst_run) begin
          state_d = RSDO_ST_RUN;
        end
      end
      RSDO_ST_RUN: begin
        if (!hw_rst_run) begin
          state_d = RSDO_ST_HELD;  // RULE1
        end
      end
      default: begin
        state_d = RSDO_ST_POWERUP;
      end
    endcase
    // Rest of the device runs only once the sequencer is in the run phase
    core_reset_n_d = (state_d == RSDO_ST_RUN);  // RULE1
  end

  // Registers the sequencing state
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q        <= RSDO_ST_POWERUP;
      core_reset_n_q <= 1'h0;
    end else begin
      state_q        <= state_d;
      core_reset_n_q <= core_reset_n_d;
    end
  end

  // ----------------------------------------------------------------
  // Oscillator run control
  // ----------------------------------------------------------------
  // Only power-on reset touches it; the pin reset does not
  always_comb begin
    osc_run_d = OSC_ON;  // RULE2
  end

  // Registers the oscillator enable
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_run_q <= OSC_ON;
    end else begin
      osc_run_q <= osc_run_d;
    end
  end

  // ----------------------------------------------------------------
  // Mode register and shared pin drivers
  // ----------------------------------------------------------------
  // Next mode value; reset wins over a write in the same cycle
  always_comb begin
    mode_d = mode_q;
    if (!hw_rst_run) begin
      mode_d = MODE_RESET;  // RULE1 RULE7
    end else if (mode_wr_en) begin
      mode_d = mode_wr_data;  // RULE5 RULE6
    end
    // Pin a: digital output one when enabled, else analog input
    pin_a_oe_n_d = ~mode_d[MODE_BIT_DEN];  // RULE3
    pin_a_o_d    = mode_d[MODE_BIT_DEN] ? mode_d[MODE_BIT_ONE] : PIN_RESET;  // RULE5
    // Pin b: digital output zero when enabled, else analog input
    pin_b_oe_n_d = ~mode_d[MODE_BIT_DEN];  // RULE4
    pin_b_o_d    = mode_d[MODE_BIT_DEN] ? mode_d[MODE_BIT_ZERO] : PIN_RESET;  // RULE6
  end

  // Registers mode and pin state together so they never disagree
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q       <= MODE_RESET;  // RULE7
      pin_a_o_q    <= PIN_RESET;
      pin_a_oe_n_q <= OE_N_OFF;
      pin_b_o_q    <= PIN_RESET;
      pin_b_oe_n_q <= OE_N_OFF;
    end else begin
      mode_q       <= mode_d;
      pin_a_o_q    <= pin_a_o_d;
      pin_a_oe_n_q <= pin_a_oe_n_d;
      pin_b_o_q    <= pin_b_o_d;
      pin_b_oe_n_q <= pin_b_oe_n_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // All straight from flip-flops
  assign core_reset_n        = core_reset_n_q;
  assign osc_run             = osc_run_q;
  assign mode_rd_data        = mode_q;
  assign shared_pin_a_o      = pin_a_o_q;
  assign shared_pin_a_oe_n   = pin_a_oe_n_q;
  assign shared_pin_a_analog = pin_a_oe_n_q;
  assign shared_pin_b_o      = pin_b_o_q;
  assign shared_pin_b_oe_n   = pin_b_oe_n_q;
  assign shared_pin_b_analog = pin_b_oe_n_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Pin low reaches the core reset three edges later
  pin_reset_core_a: assert property (!hw_reset_pin_n |-> ##3 !core_reset_n_q) // RULE1
    else $error("core reset not asserted three cycles after reset pin low");

  // Pin low clears the mode register three edges later
  pin_reset_mode_a: assert property (!hw_reset_pin_n |-> ##3 (mode_q == MODE_RESET)) // RULE1
    else $error("mode register not cleared by reset pin");

  // Oscillator keeps running through a pin reset
  osc_keeps_run_a: assert property (!core_reset_n_q |-> osc_run_q) // RULE2
    else $error("oscillator stopped during hardware reset");

  // Pin a direction follows the enable bit
  pin_a_dir_a: assert property (shared_pin_a_oe_n == !mode_q[MODE_BIT_DEN]) // RULE3
    else $error("pin a direction disagrees with enable bit");

  // Pin b direction follows the same enable bit
  pin_b_dir_a: assert property (shared_pin_b_oe_n == shared_pin_a_oe_n) // RULE4
    else $error("pin b direction disagrees with pin a");

  // Written bit one appears on pin a one edge later
  pin_a_write_a: assert property ((mode_wr_en && hw_rst_run
      && mode_wr_data[MODE_BIT_DEN]) |=> (!shared_pin_a_oe_n
      && shared_pin_a_o == $past(mode_wr_data[MODE_BIT_ONE]))) // RULE5
    else $error("pin a does not show written output bit one");

  // Written bit zero appears on pin b one edge later
  pin_b_write_a: assert property ((mode_wr_en && hw_rst_run
      && mode_wr_data[MODE_BIT_DEN]) |=> (!shared_pin_b_oe_n
      && shared_pin_b_o == $past(mode_wr_data[MODE_BIT_ZERO]))) // RULE6
    else $error("pin b does not show written output bit zero");

  // Pins stay undriven while the rest of the device is in reset
  reset_pins_off_a: assert property (!core_reset_n_q |-> (shared_pin_a_oe_n
      && shared_pin_b_oe_n)) // RULE7
    else $error("shared pin driven during reset");

  // Mode holds when nothing writes and no reset is pending
  mode_hold_a: assert property ((!mode_wr_en && hw_rst_run) |=> $stable(mode_q)) // RULE5
    else $error("mode register changed without a write");

  // Main scenarios
  enable_cov: cover property (mode_wr_en && hw_rst_run && mode_wr_data[MODE_BIT_DEN]);
  reset_in_use_cov: cover property ((!shared_pin_a_oe_n && !hw_rst_run)
      ##1 (shared_pin_a_oe_n && !core_reset_n_q));
  write_during_reset_cov: cover property (mode_wr_en && !hw_rst_run);

endmodule : rsdo_top

`default_nettype wire

// >>> verification/rsdo_host.sv
/*
  Host controller model: drives the hardware reset pin and mode writes.
  Assumes the device samples both on the rising edge of sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module rsdo_host (
  input  wire logic            sys_clk,
  output logic                 hw_reset_pin_n,
  output logic                 mode_wr_en,
  output rsdo_pkg::rsdo_mode_t mode_wr_data
);
  import rsdo_pkg::*;

  // Idle levels from time zero
  initial begin
    hw_reset_pin_n = 1'h1;
    mode_wr_en     = 1'h0;
    mode_wr_data   = 3'h0;
  end

  // One-cycle strobe carrying the whole mode word
  task automatic write_mode(input rsdo_mode_t value);
    @(posedge sys_clk);
    mode_wr_en   <= 1'h1;
    mode_wr_data <= value;
    @(posedge sys_clk);
    mode_wr_en   <= 1'h0;
    mode_wr_data <= ~value;  // Stale data must not look valid
  endtask : write_mode

  // Moves the reset pin at a clock edge
  task automatic set_reset_pin(input logic level);
    @(posedge sys_clk);
    hw_reset_pin_n <= level;
  endtask : set_reset_pin

endmodule : rsdo_host

`default_nettype wire

// >>> verification/test_reset_and_shared_digital_outputs.sv
/*
  Self-checking bench for the reset and shared digital output block.
  Assumes the host model drives all pin and write inputs on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module test_reset_and_shared_digital_outputs;
  import rsdo_pkg::*;

  logic       sys_clk;
  logic       rst_n;
  wire logic  hw_reset_pin_n;
  wire logic  mode_wr_en;
  rsdo_mode_t mode_wr_data;
  logic       core_reset_n;
  logic       osc_run;
  rsdo_mode_t mode_rd_data;
  logic       pa_o;
  logic       pa_oe_n;
  logic       pa_an;
  logic       pb_o;
  logic       pb_oe_n;
  logic       pb_an;
  int         errors;
  int         checks_done;
  int         cycles;

  rsdo_host rsdo_host_i (.sys_clk(sys_clk), .hw_reset_pin_n(hw_reset_pin_n),
    .mode_wr_en(mode_wr_en), .mode_wr_data(mode_wr_data));

  rsdo_top rsdo_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .hw_reset_pin_n(hw_reset_pin_n),
    .mode_wr_en(mode_wr_en), .mode_wr_data(mode_wr_data), .core_reset_n(core_reset_n),
    .osc_run(osc_run), .mode_rd_data(mode_rd_data), .shared_pin_a_o(pa_o),
    .shared_pin_a_oe_n(pa_oe_n), .shared_pin_a_analog(pa_an), .shared_pin_b_o(pb_o),
    .shared_pin_b_oe_n(pb_oe_n), .shared_pin_b_analog(pb_an));

  // 10 MHz clock
  initial sys_clk = 1'h0;
  always #50 sys_clk = ~sys_clk;

  // Hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 1000) begin
      errors++;
      wrap_up();
    end
  end

  // Compares one value and reports a mismatch
  task automatic chk(input string what, input logic [2:0] exp, input logic [2:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Mode readback and both pins against the mode word
  task automatic check_mode(input rsdo_mode_t m);
    logic en;
    en = m[MODE_BIT_DEN];
    chk("mode", m, mode_rd_data);
    chk("pin_a", {en & m[MODE_BIT_ONE], ~en, ~en}, {pa_o, pa_oe_n, pa_an});
    chk("pin_b", {en & m[MODE_BIT_ZERO], ~en, ~en}, {pb_o, pb_oe_n, pb_an});
  endtask : check_mode

  // Reset and oscillator status
  task automatic check_core(input logic core_n);
    chk("core_osc", {1'h0, core_n, 1'h1}, {1'h0, core_reset_n, osc_run});
  endtask : check_core

  // Power-on state after reset
  task automatic test_after_reset;
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    check_core(1'h1);
    check_mode(3'h0);
  endtask : test_after_reset

  // Every mode word, enabled and disabled
  task automatic test_all_modes;
    for (int i = 0; i < 8; i++) begin
      rsdo_host_i.write_mode(3'(i));
      @(negedge sys_clk);
      check_mode(3'(i));
    end
  endtask : test_all_modes

  // Pin reset clears everything but the oscillator and refuses writes
  task automatic test_pin_reset;
    rsdo_host_i.write_mode(3'h7);
    rsdo_host_i.set_reset_pin(1'h0);
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    check_core(1'h0);
    check_mode(3'h0);
    rsdo_host_i.write_mode(3'h6);
    @(negedge sys_clk);
    check_mode(3'h0);
    rsdo_host_i.set_reset_pin(1'h1);
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    check_core(1'h1);
    check_mode(3'h0);
    rsdo_host_i.write_mode(3'h5);
    @(negedge sys_clk);
    check_mode(3'h5);
  endtask : test_pin_reset

  // Verdict and end of run
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  // Main sequence
  initial begin
    errors      = 0;
    checks_done = 0;
    cycles      = 0;
    rst_n       = 1'h0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'h1;
    test_after_reset();
    test_all_modes();
    test_pin_reset();
    wrap_up();
  end

endmodule : test_reset_and_shared_digital_outputs

`default_nettype wire
